// file: hw/lmu_pkg.sv
// What this block does
// - Only seven-bit addresses are answered; ten-bit and CBUS traffic gets no acknowledge.
// - Works at 100 kbit/s standard and 400 kbit/s fast bus rates.
// - Fixed address 1110000 plus direction bit: E0h write, E1h read.
// - Twenty-three eight-bit registers readable and writable over the bus.
// - Pointer never steps; one register per transfer.
// - Write: start, address+W, pointer, data, stop; each byte acknowledged.
// - Combined read: pointer, repeated start, address+R, acknowledge, one data byte.
// - Pointer survives stops and foreign traffic; later read returns that register.
// - Start and stop frame packets; repeated start accepted.
// - Enable low for the shutdown time returns all registers to defaults.
// - Sleep when all backlights off and not in shutdown; registers kept.
// - Bus interface stays fully active while asleep.
// - Thermal shutdown disables outputs but keeps every register.
package lmu_pkg;

  localparam int          NUM_REGS      = 23;
  localparam int          REG_W         = 8;
  localparam int          PTR_W         = 8;
  localparam logic [6:0]  SLAVE_ADDR    = 7'h70;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [7:0]  READ_VOID     = 8'h00;

  localparam int          STD_RATE_KBPS = 100;
  localparam int          FAST_RATE_KBPS = 400;
  localparam int          MIN_SCL_HIGH_NS = 600;
  localparam int          LINK_CLK_PERIOD_NS = 32;
  localparam int          SAMPLES_PER_HIGH = 4;

  localparam int          CLK_PERIOD_NS = 8;
  localparam int          SHDN_TIME_NS  = 1000;
  localparam int          SHDN_CYC      = (SHDN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SHDN_CNT_W    = 8;

  typedef enum logic [3:0] {
    LMU_IDLE   = 4'h0,
    LMU_ADDR   = 4'h1,
    LMU_AACK   = 4'h3,
    LMU_PTR    = 4'h2,
    LMU_PACK   = 4'h6,
    LMU_WDATA  = 4'h7,
    LMU_WACK   = 4'h5,
    LMU_TX     = 4'h4,
    LMU_TXACK  = 4'hc,
    LMU_IGNORE = 4'hd
  } lmu_link_state_t;

endpackage

// file: hw/lmu_sync.sv
module lmu_sync #(
  parameter int         W       = 1,
  parameter logic [0:0] RST_VAL = 1'b0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lmu_sync_t;

  lmu_sync_t s;
  lmu_sync_t next_s;

  always_comb begin
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= {(2 * W){RST_VAL}};
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.s2;

endmodule

// file: hw/lmu_regfile.sv
module lmu_regfile #(
  parameter int NUM = lmu_pkg::NUM_REGS,
  parameter int W   = lmu_pkg::REG_W
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     clr_i,
  input  wire logic                     we_i,
  input  wire logic [lmu_pkg::PTR_W-1:0] addr_i,
  input  wire logic [W-1:0]             wdata_i,
  output logic      [W-1:0]             rdata_o,
  output logic      [NUM*W-1:0]         regs_o
);

  if (NUM < 1 || NUM > 256 || W != 8) begin : g_chk
    $error("lmu_regfile: unsupported size");
  end

  typedef struct packed {
    logic [NUM-1:0][W-1:0] mem;
  } lmu_rf_t;

  lmu_rf_t r;
  lmu_rf_t next_r;
  logic    in_range;

  assign in_range = addr_i < lmu_pkg::PTR_W'(NUM);

  always_comb begin
    next_r = r;
    if (clr_i) begin
      next_r.mem = {NUM{lmu_pkg::REG_RESET}};
    end else if (we_i && in_range) begin
      next_r.mem[addr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r.mem <= {NUM{lmu_pkg::REG_RESET}};
    end else begin
      r <= next_r;
    end
  end

  assign rdata_o = in_range ? r.mem[addr_i] : lmu_pkg::READ_VOID;
  assign regs_o  = r.mem;

endmodule

// file: hw/lmu_i2c_slave.sv
module lmu_i2c_slave #(
  parameter int SHDN_CYC = lmu_pkg::SHDN_CYC
) (
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_b_i,
  input  wire logic                                   link_clk_i,
  input  wire logic                                   scl_i,
  input  wire logic                                   sda_i,
  output logic                                        sda_o,
  output logic                                        sda_oe_o,
  input  wire logic                                   en_i,
  input  wire logic                                   bl_on_i,
  input  wire logic                                   ot_i,
  output logic      [lmu_pkg::NUM_REGS*lmu_pkg::REG_W-1:0] regs_o,
  output logic                                        shutdown_o,
  output logic                                        sleep_o,
  output logic                                        out_en_o
);

  if (SHDN_CYC < 1 || SHDN_CYC >= (1 << lmu_pkg::SHDN_CNT_W)) begin : g_chk_shdn
    $error("lmu_i2c_slave: shutdown count out of range");
  end
  if (lmu_pkg::LINK_CLK_PERIOD_NS * lmu_pkg::SAMPLES_PER_HIGH > lmu_pkg::MIN_SCL_HIGH_NS)
  begin : g_chk_rate
    $error("lmu_i2c_slave: link clock too slow for fast mode");
  end
  if (lmu_pkg::REG_W != 8 || lmu_pkg::PTR_W != 8) begin : g_chk_width
    $error("lmu_i2c_slave: link logic assumes byte-wide registers and pointer");
  end

  // Link side state
  typedef struct packed {
    lmu_pkg::lmu_link_state_t st;
    logic [2:0]               cnt;
    logic                     full;
    logic [7:0]               sh;
    logic                     rw;
    logic [7:0]               ptr;
    logic                     scl_d;
    logic                     sda_d;
    logic                     req_tgl;
    logic                     req_we;
    logic [7:0]               req_addr;
    logic [7:0]               req_data;
    logic                     ack_d;
    logic [7:0]               rdata;
    logic                     sda_oe;
  } lmu_link_t;

  // Core side state
  typedef struct packed {
    logic [lmu_pkg::SHDN_CNT_W-1:0] en_cnt;
    logic                           shdn;
    logic                           req_d;
    logic                           ack_tgl;
    logic [7:0]                     rdata;
    logic                           sleep;
    logic                           out_en;
  } lmu_core_t;

  lmu_link_t  l;
  lmu_link_t  next_l;
  lmu_core_t  c;
  lmu_core_t  next_c;

  logic       scl_s;
  logic       sda_s;
  logic       ack_s;
  logic       req_s;
  logic       en_s;
  logic       ot_s;
  logic       start;
  logic       stop;
  logic       scl_rise;
  logic       scl_fall;
  logic       req_edge;
  logic       rf_we;
  logic [7:0] rf_rdata;
  logic       shdn_clr;

  // Link clock domain
  lmu_sync #(
    .W       (2),
    .RST_VAL (1'b1)
  ) u_sync_bus (
    .clk_i   (link_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({scl_i, sda_i}),
    .q_o     ({scl_s, sda_s})
  );

  lmu_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_sync_ack (
    .clk_i   (link_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (c.ack_tgl),
    .q_o     (ack_s)
  );

  assign start    = l.scl_d && scl_s && l.sda_d && !sda_s;
  assign stop     = l.scl_d && scl_s && !l.sda_d && sda_s;
  assign scl_rise = !l.scl_d && scl_s;
  assign scl_fall = l.scl_d && !scl_s;

  always_comb begin
    next_l       = l;
    next_l.scl_d = scl_s;
    next_l.sda_d = sda_s;
    next_l.ack_d = ack_s;
    if (ack_s != l.ack_d) begin
      next_l.rdata = c.rdata;
    end
    case (l.st)
      lmu_pkg::LMU_ADDR, lmu_pkg::LMU_PTR, lmu_pkg::LMU_WDATA: begin
        if (scl_rise) begin
          next_l.sh  = {l.sh[6:0], sda_s};
          next_l.cnt = l.cnt + 3'h1;
          if (l.cnt == 3'h7) begin
            next_l.full = 1'b1;
          end
        end else if (scl_fall && l.full) begin
          next_l.full   = 1'b0;
          next_l.sda_oe = 1'b1;
          if (l.st == lmu_pkg::LMU_ADDR) begin
            if (l.sh[7:1] == lmu_pkg::SLAVE_ADDR) begin
              next_l.st = lmu_pkg::LMU_AACK;
              next_l.rw = l.sh[0];
              if (l.sh[0]) begin
                next_l.req_tgl  = ~l.req_tgl;
                next_l.req_we   = 1'b0;
                next_l.req_addr = l.ptr;
              end
            end else begin
              next_l.sda_oe = 1'b0;
              next_l.st     = lmu_pkg::LMU_IGNORE;
            end
          end else if (l.st == lmu_pkg::LMU_PTR) begin
            next_l.ptr = l.sh;
            next_l.st  = lmu_pkg::LMU_PACK;
          end else begin
            next_l.req_tgl  = ~l.req_tgl;
            next_l.req_we   = 1'b1;
            next_l.req_addr = l.ptr;
            next_l.req_data = l.sh;
            next_l.st       = lmu_pkg::LMU_WACK;
          end
        end
      end
      lmu_pkg::LMU_AACK: begin
        if (scl_fall) begin
          next_l.cnt = 3'h0;
          if (l.rw) begin
            next_l.st     = lmu_pkg::LMU_TX;
            next_l.sh     = l.rdata;
            next_l.sda_oe = ~l.rdata[7];
          end else begin
            next_l.st     = lmu_pkg::LMU_PTR;
            next_l.sda_oe = 1'b0;
          end
        end
      end
      lmu_pkg::LMU_PACK: begin
        if (scl_fall) begin
          next_l.st     = lmu_pkg::LMU_WDATA;
          next_l.sda_oe = 1'b0;
        end
      end
      lmu_pkg::LMU_WACK: begin
        if (scl_fall) begin
          next_l.st     = lmu_pkg::LMU_IGNORE;
          next_l.sda_oe = 1'b0;
        end
      end
      lmu_pkg::LMU_TX: begin
        if (scl_rise) begin
          next_l.cnt = l.cnt + 3'h1;
          if (l.cnt == 3'h7) begin
            next_l.full = 1'b1;
          end
        end else if (scl_fall) begin
          if (l.full) begin
            next_l.full   = 1'b0;
            next_l.sda_oe = 1'b0;
            next_l.st     = lmu_pkg::LMU_TXACK;
          end else begin
            next_l.sh     = {l.sh[6:0], 1'b0};
            next_l.sda_oe = ~l.sh[6];
          end
        end
      end
      lmu_pkg::LMU_TXACK: begin
        if (scl_fall) begin
          next_l.st = lmu_pkg::LMU_IGNORE;
        end
      end
      lmu_pkg::LMU_IDLE, lmu_pkg::LMU_IGNORE: begin
        next_l.sda_oe = 1'b0;
      end
      default: begin
        next_l.st     = lmu_pkg::LMU_IDLE;
        next_l.sda_oe = 1'b0;
      end
    endcase
    if (start) begin
      next_l.st     = lmu_pkg::LMU_ADDR;
      next_l.cnt    = 3'h0;
      next_l.full   = 1'b0;
      next_l.sda_oe = 1'b0;
    end else if (stop) begin
      next_l.st     = lmu_pkg::LMU_IDLE;
      next_l.full   = 1'b0;
      next_l.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      l          <= '0;
      l.st       <= lmu_pkg::LMU_IDLE;
      l.scl_d    <= 1'b1;
      l.sda_d    <= 1'b1;
    end else begin
      l <= next_l;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = l.sda_oe;

  // Core clock domain
  lmu_sync #(
    .W       (2),
    .RST_VAL (1'b0)
  ) u_sync_core (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({l.req_tgl, ot_i}),
    .q_o     ({req_s, ot_s})
  );

  // Enable pin rests high out of reset
  lmu_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_sync_en (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (en_i),
    .q_o     (en_s)
  );

  assign req_edge = req_s != c.req_d;
  assign shdn_clr = next_c.shdn;
  assign rf_we    = req_edge && l.req_we && !c.shdn;

  lmu_regfile #(
    .NUM (lmu_pkg::NUM_REGS),
    .W   (lmu_pkg::REG_W)
  ) u_regs (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (shdn_clr),
    .we_i    (rf_we),
    .addr_i  (l.req_addr),
    .wdata_i (l.req_data),
    .rdata_o (rf_rdata),
    .regs_o  (regs_o)
  );

  always_comb begin
    next_c       = c;
    next_c.req_d = req_s;
    if (en_s) begin
      next_c.en_cnt = '0;
      next_c.shdn   = 1'b0;
    end else if (c.en_cnt == lmu_pkg::SHDN_CNT_W'(SHDN_CYC - 1)) begin
      next_c.shdn = 1'b1;
    end else begin
      next_c.en_cnt = c.en_cnt + 1'b1;
    end
    if (req_edge) begin
      next_c.ack_tgl = ~c.ack_tgl;
      if (!l.req_we) begin
        next_c.rdata = rf_rdata;
      end
    end
    next_c.sleep  = !bl_on_i && !c.shdn;
    next_c.out_en = !c.shdn && !ot_s;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign shutdown_o = c.shdn;
  assign sleep_o    = c.sleep;
  assign out_en_o   = c.out_en;

endmodule

// file: tb/lmu_props.sv
module lmu_props #(
  parameter int SHDN_CYC = 4
) (
  input wire logic                                         clk_i,
  input wire logic                                         rst_b_i,
  input wire logic                                         link_clk_i,
  input wire logic                                         scl_i,
  input wire logic                                         sda_i,
  input wire logic                                         sda_o,
  input wire logic                                         sda_oe_o,
  input wire logic                                         en_i,
  input wire logic                                         bl_on_i,
  input wire logic                                         ot_i,
  input wire logic [lmu_pkg::NUM_REGS*lmu_pkg::REG_W-1:0] regs_o,
  input wire logic                                         shutdown_o,
  input wire logic                                         sleep_o,
  input wire logic                                         out_en_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int lo_cnt;

  // Consecutive cycles with the enable pin low
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lo_cnt <= 0;
    end else if (en_i) begin
      lo_cnt <= 0;
    end else if (lo_cnt < 1000) begin
      lo_cnt <= lo_cnt + 1;
    end
  end

  a_oe_scl_low: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    $changed(sda_oe_o) |-> !scl_i) else $error("sda drive changed while scl high");
  a_open_drain: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    sda_o == 1'b0) else $error("sda driven high");
  a_shdn_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    shutdown_o |-> regs_o == '0) else $error("registers not default in shutdown");
  a_shdn_early: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(shutdown_o) |-> lo_cnt >= SHDN_CYC) else $error("shutdown too early");
  a_shdn_late: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    lo_cnt == SHDN_CYC + 5 |-> shutdown_o) else $error("shutdown missing");
  a_shdn_exit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    en_i [*4] |=> !shutdown_o) else $error("shutdown not released");
  a_sleep_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!bl_on_i && !shutdown_o) [*2] |=> sleep_o || shutdown_o) else $error("sleep missing");
  a_sleep_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bl_on_i |=> !sleep_o) else $error("sleep with backlight on");
  a_ot_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ot_i [*4] |=> !out_en_o) else $error("outputs on while over temperature");
  a_out_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!ot_i && en_i) [*6] |=> out_en_o) else $error("outputs not re-enabled");

  c_ack: cover property (@(posedge link_clk_i) disable iff (!rst_b_i) $rose(sda_oe_o));
  c_shdn: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(shutdown_o));
  c_sleep: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(sleep_o));
  c_ot: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(out_en_o) && !shutdown_o);
endmodule

bind lmu_i2c_slave lmu_props #(.SHDN_CYC(SHDN_CYC)) props_u (.clk_i, .rst_b_i, .link_clk_i,
  .scl_i, .sda_i, .sda_o, .sda_oe_o, .en_i, .bl_on_i, .ot_i, .regs_o, .shutdown_o, .sleep_o,
  .out_en_o);

// file: tb/lmu_host.sv
module lmu_host (
  input  wire logic link_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int q = 4;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tk();
    repeat (q) @(posedge link_clk_i);
    #1;
  endtask
  task automatic st(logic s);
    sda_o = s;
    tk();
  endtask
  task automatic sc(logic c);
    scl_o = c;
    tk();
  endtask
  task automatic bitx(input logic b, output logic r);
    st(b);
    sc(1'b1);
    r = sda_i;
    sc(1'b0);
  endtask
  task automatic start();
    st(1'b1);
    sc(1'b1);
    st(1'b0);
    sc(1'b0);
  endtask
  task automatic stop();
    st(1'b0);
    sc(1'b1);
    st(1'b1);
  endtask
  task automatic wbyte(input logic [7:0] v, output logic [7:0] a);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, r);
    a = {7'h00, !r};
  endtask
  task automatic rbyte(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(1'b1, r);
  endtask
endmodule

// file: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SC = 4;
  localparam int RW = lmu_pkg::NUM_REGS * lmu_pkg::REG_W;
  logic          clk_i = 1'b0;
  logic          link_clk_i = 1'b0;
  logic          rst_b_i = 1'b0;
  logic          en_i = 1'b1;
  logic          bl_on_i = 1'b1;
  logic          ot_i = 1'b0;
  logic          scl;
  logic          sda_m;
  logic          sda_o;
  logic          sda_oe_o;
  logic          shutdown_o;
  logic          sleep_o;
  logic          out_en_o;
  logic [RW-1:0] regs_o;
  wire logic     sda_w;
  logic [7:0]    k;
  logic [7:0]    d;
  logic [7:0]    fa[3] = '{8'he2, 8'hf0, 8'h02};
  int            miscompares = 0;
  int            cmp_count = 0;
  int            seed = 43;
  int            ptr = 0;
  int            mdl[lmu_pkg::NUM_REGS];

  // Open-drain wire with pull-up
  assign sda_w = sda_m & (sda_oe_o ? sda_o : 1'b1);

  initial forever #4 clk_i = ~clk_i;
  initial begin
    #5;
    forever #16 link_clk_i = ~link_clk_i;
  end

  lmu_i2c_slave #(.SHDN_CYC(SC)) dut_u (.clk_i, .rst_b_i, .link_clk_i, .scl_i(scl),
    .sda_i(sda_w), .sda_o, .sda_oe_o, .en_i, .bl_on_i, .ot_i, .regs_o, .shutdown_o,
    .sleep_o, .out_en_o);
  lmu_host host_u (.link_clk_i, .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));

  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_regs();
    logic [RW-1:0] e;
    for (int i = 0; i < lmu_pkg::NUM_REGS; i++) e[8*i+:8] = mdl[i][7:0];
    cmp_count++;
    if (regs_o !== e) begin
      miscompares++;
      $display("[ERR] regs exp %h got %h", e, regs_o);
    end
  endtask
  task automatic sp(logic [7:0] a, logic [7:0] p);
    logic [7:0] e;
    e = {7'h00, a == 8'he0};
    host_u.start();
    host_u.wbyte(a, k);
    chk("ack_addr", e, k);
    host_u.wbyte(p, k);
    chk("ack_ptr", e, k);
    if (e[0]) ptr = p;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] p, logic [7:0] dv);
    sp(a, p);
    host_u.wbyte(dv, k);
    chk("ack_data", {7'h00, a == 8'he0}, k);
    host_u.stop();
    if (a == 8'he0 && p < 23) mdl[p] = dv;
    cyc(8);
  endtask
  task automatic rdb();
    host_u.start();
    host_u.wbyte(8'he1, k);
    chk("ack_rd", 8'h01, k);
    host_u.rbyte(d);
    chk("rdata", ptr < 23 ? 8'(mdl[ptr]) : 8'h00, d);
    host_u.stop();
  endtask

  initial begin
    int n;
    cyc(12);
    rst_b_i = 1'b1;
    cyc(24);
    chk_regs();
    host_u.q = 105;
    wr(8'he0, 8'h05, 8'ha5);
    host_u.q = 27;
    sp(8'he0, 8'h05);
    rdb();
    host_u.q = 4;
    repeat (4) begin
      wr(8'he0, 8'($unsigned($random(seed)) % 23), 8'($random(seed)));
      chk_regs();
      sp(8'he0, 8'($unsigned($random(seed)) % 23));
      rdb();
    end
    wr(8'he0, 8'h16, 8'hc3);
    wr(8'he0, 8'h17, 8'h5a);
    wr(8'he0, 8'hff, 8'h33);
    chk_regs();
    rdb();
    for (int i = 0; i < 3; i++) begin
      wr(fa[i], 8'h03, 8'h77);
      chk_regs();
    end
    sp(8'he0, 8'h16);
    host_u.stop();
    wr(8'he2, 8'h09, 8'h11);
    rdb();
    rdb();
    cyc(1);
    bl_on_i = 1'b0;
    cyc(3);
    chk("sleep", 8'h01, {7'h00, sleep_o});
    wr(8'he0, 8'h07, 8'h9c);
    sp(8'he0, 8'h07);
    rdb();
    chk_regs();
    bl_on_i = 1'b1;
    cyc(3);
    chk("sleep", 8'h00, {7'h00, sleep_o});
    ot_i = 1'b1;
    cyc(6);
    chk("out_en", 8'h00, {7'h00, out_en_o});
    chk_regs();
    ot_i = 1'b0;
    cyc(6);
    chk("out_en", 8'h01, {7'h00, out_en_o});
    en_i = 1'b0;
    for (n = 0; n < 60 && shutdown_o !== 1'b1; n++) cyc(1);
    chk("shutdown", 8'h01, {7'h00, shutdown_o});
    if (shutdown_o !== 1'b1) finish_test();
    chk("shdn_wait", 8'h01, {7'h00, n >= SC});
    foreach (mdl[i]) mdl[i] = 0;
    chk_regs();
    en_i = 1'b1;
    cyc(6);
    chk("shutdown", 8'h00, {7'h00, shutdown_o});
    wr(8'he0, 8'h01, 8'h3c);
    sp(8'he0, 8'h01);
    rdb();
    chk_regs();
    finish_test();
  end
endmodule
